//--- hw/overcurrent_retry_field_defs.svh
// Constants for the overcurrent retry and current-limit block
`ifndef OVERCURRENT_RETRY_FIELD_DEFS_SVH
`define OVERCURRENT_RETRY_FIELD_DEFS_SVH

`define OFF_PRESENT 8'h03
`define OFF_FAULT 8'h04
`define OFF_RETRY 8'h0B
`define OFF_LIMCFG 8'h0D
`define OFF_TIMING 8'h0E
`define OFF_RESTART 8'hA2
`define OFF_NVLIM 8'hAD
`define OFF_SCRATCH_LO 8'hE9
`define OFF_SCRATCH_HI 8'hEF

`define BIT_OC_PRESENT 0
`define BIT_OVERCURRENT_FAULT_LATCH 0
`define BIT_DELAY_RUN 0
`define RETRY_LSB 0
`define COOL_LSB 0
`define LIMIT_SENSE_FIELD_LSB 0
`define FB_LSB 4
`define BIT_LOAD_POWER_FOLDBACK_BIT 6
`define BIT_FBDIS 7

`define RETRY_NONE 2'h0
`define RETRY_ONE 2'h1
`define RETRY_SEVEN 2'h2
`define RETRY_COUNT_ONE 3'h1
`define RETRY_COUNT_SEVEN 3'h7

`define NVLIM_RESET 8'h05
`define RETRY_RESET 8'h00
`define TIMING_RESET 8'h00

`define LIMIT_SENSE_FIELD_BASE_MV 15
`define FB_PCT10 10'd100
`define FB_PCT20 10'd200
`define FB_PCT50 10'd500
`define FB_FULL 10'd1000
`define KNEE_MV 900
`define LOAD_POWER_FOLDBACK_BIT_END_MV 1800

`define CLK_PERIOD_NS 8
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_PERIOD_NS)
`define COOL_MIN_MS 17'd512
`define CNT_RESET_MS 17'd16400

`endif

//--- hw/overcurrent_retry_field_pkg.sv
// Types for the overcurrent retry and current-limit block
`default_nettype none
package overcurrent_retry_field_pkg;

   typedef enum logic [1:0] {
      ST_RUN = 2'h0,
      ST_COOL = 2'h1,
      ST_HOLD = 2'h3
   } gate_state_t;

   typedef struct packed {
      logic [1:0] engSync;
      logic [1:0] tmrSync;
      logic [1:0] pgSync;
      logic [1:0] onSync;
      logic tmrPrev;
      logic loadPending;
      gate_state_t state;
      logic ocPresent;
      logic ocFault;
      logic [7:0] retryCtl;
      logic [7:0] limCfg;
      logic [7:0] timingCfg;
      logic [7:0] nvLim;
      logic [16:0] tickCnt;
      logic [16:0] coolMs;
      logic [16:0] resetMs;
      logic resetRun;
      logic [2:0] retriesUsed;
      logic [7:0] rdData;
      logic gateEnable;
      logic gatePullDown;
      logic [15:0] limitUv;
   } state_t;

endpackage : overcurrent_retry_field_pkg
`default_nettype wire

//--- hw/overcurrent_retry_field_limit.sv
// Overcurrent fault, auto-retry and current-limit foldback control
`timescale 1ns/1ps
`default_nettype none
`include "overcurrent_retry_field_defs.svh"

module overcurrent_retry_field_limit #(
   parameter int unsigned MS_CYCLES = `MS_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic limitEngagedPin,
   input wire logic timerThresholdPin,
   input wire logic powerGoodPin,
   input wire logic turnOnRequestPin,
   input wire logic [11:0] outputSenseMv,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [7:0] regRdData,
   output logic gateEnable,
   output logic gatePullDown,
   output logic delayRunning,
   output logic [4:0] limitSenseMv,
   output logic [5:0] fastPulldownMv,
   output logic [15:0] effectiveLimitUv
);

   ////////////////////////////////////////////////////////////////////////
   // State, reset constant and scratch storage

   localparam overcurrent_retry_field_pkg::state_t RESET_STATE = '{
      engSync: 2'h0, tmrSync: 2'h0, pgSync: 2'h0, onSync: 2'h0,
      tmrPrev: 1'b0, loadPending: 1'b1, state: overcurrent_retry_field_pkg::ST_RUN,
      ocPresent: 1'b0, ocFault: 1'b0, retryCtl: `RETRY_RESET,
      limCfg: `NVLIM_RESET, timingCfg: `TIMING_RESET, nvLim: `NVLIM_RESET,
      tickCnt: 17'h0, coolMs: 17'h0, resetMs: 17'h0, resetRun: 1'b0,
      retriesUsed: 3'h0, rdData: 8'h00, gateEnable: 1'b0,
      gatePullDown: 1'b0, limitUv: 16'h0000
   };
   localparam logic [16:0] TICK_LAST = 17'(MS_CYCLES - 1);

   overcurrent_retry_field_pkg::state_t s_reg;
   overcurrent_retry_field_pkg::state_t s_next;

   logic [7:0] scratch_reg [0:6];
   logic [7:0] scratch_next [0:6];

   ////////////////////////////////////////////////////////////////////////
   // Decoded configuration

   logic [1:0] retrySel;
   logic [2:0] coolSel;
   logic [3:0] ilimSel;
   logic [1:0] fbSel;
   logic lpfbOn;
   logic fbDisable;
   logic [4:0] vilimMv;
   logic [9:0] fbFloor;
   logic [2:0] retryLimit;
   logic msTick;
   logic faultEvent;
   logic [16:0] coolLen;
   logic [9:0] ratio;
   logic [31:0] ratioWork;
   logic [31:0] vWork;

   assign retrySel = s_reg.retryCtl[`RETRY_LSB +: 2];
   assign coolSel = s_reg.timingCfg[`COOL_LSB +: 3];
   assign ilimSel = s_reg.limCfg[`LIMIT_SENSE_FIELD_LSB +: 4];
   assign fbSel = s_reg.limCfg[`FB_LSB +: 2];
   assign lpfbOn = s_reg.limCfg[`BIT_LOAD_POWER_FOLDBACK_BIT];
   assign fbDisable = s_reg.limCfg[`BIT_FBDIS];
   // 1 mV steps from 15 mV
   assign vilimMv = 5'(`LIMIT_SENSE_FIELD_BASE_MV) + {1'b0, ilimSel};
   // 512 ms doubled per code step
   assign coolLen = `COOL_MIN_MS << coolSel;
   assign msTick = (s_reg.tickCnt == TICK_LAST);
   assign faultEvent = s_reg.tmrSync[1] & ~s_reg.tmrPrev & (s_reg.state == overcurrent_retry_field_pkg::ST_RUN);

   ////////////////////////////////////////////////////////////////////////
   // Retry count and foldback floor

   always_comb begin
      case (retrySel)
         `RETRY_ONE: retryLimit = `RETRY_COUNT_ONE;
         `RETRY_SEVEN: retryLimit = `RETRY_COUNT_SEVEN;
         default: retryLimit = 3'h0;
      endcase
      case (fbSel)
         2'h0: fbFloor = `FB_PCT10;
         2'h1: fbFloor = `FB_PCT20;
         2'h2: fbFloor = `FB_PCT50;
         default: fbFloor = `FB_FULL;
      endcase
   end

   // Divides by constant knee width; one combinational path, no iteration
   always_comb begin
      vWork = {20'h0, outputSenseMv};
      ratioWork = 32'(`FB_FULL);
      if (s_reg.state != overcurrent_retry_field_pkg::ST_RUN || !s_reg.pgSync[1]) begin
         ratioWork = {22'h0, fbFloor};
      end else if (vWork < 32'(`KNEE_MV)) begin
         if (!fbDisable) begin
            ratioWork = {22'h0, fbFloor} + ((32'(`FB_FULL) - {22'h0, fbFloor}) * vWork) / 32'(`KNEE_MV);
         end
      end else if (lpfbOn) begin
         if (vWork >= 32'(`LOAD_POWER_FOLDBACK_BIT_END_MV)) begin
            ratioWork = 32'(`FB_PCT50);
         end else begin
            ratioWork = 32'(`FB_FULL) - (32'(`FB_PCT50) * (vWork - 32'(`KNEE_MV))) / 32'(`KNEE_MV);
         end
      end
      // disable bit only gates the normal rise branch
      ratio = ratioWork[9:0];
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      s_next = s_reg;
      for (int i = 0; i < 7; i++) begin
         scratch_next[i] = scratch_reg[i];
      end

      s_next.engSync = {s_reg.engSync[0], limitEngagedPin};
      s_next.tmrSync = {s_reg.tmrSync[0], timerThresholdPin};
      s_next.pgSync = {s_reg.pgSync[0], powerGoodPin};
      s_next.onSync = {s_reg.onSync[0], turnOnRequestPin};
      s_next.tmrPrev = s_reg.tmrSync[1];
      s_next.tickCnt = msTick ? 17'h0 : s_reg.tickCnt + 17'h1;

      // defaults from nonvolatile copy after reset
      if (s_reg.loadPending) begin
         s_next.limCfg = s_reg.nvLim;
         s_next.loadPending = 1'b0;
      end

      // reset timer frozen without power good
      if (s_reg.resetRun && s_reg.pgSync[1] && msTick) begin
         if (s_reg.resetMs == 17'h0) begin
            s_next.resetRun = 1'b0;
            s_next.retriesUsed = 3'h0;
         end else begin
            s_next.resetMs = s_reg.resetMs - 17'h1;
         end
      end

      case (s_reg.state)
         overcurrent_retry_field_pkg::ST_RUN: begin
            s_next.ocPresent = s_reg.engSync[1] & s_reg.gateEnable;
            if (faultEvent) begin
               s_next.ocFault = 1'b1;
               s_next.gatePullDown = 1'b1;
               s_next.coolMs = coolLen;
               s_next.state = overcurrent_retry_field_pkg::ST_COOL;
            end
         end
         overcurrent_retry_field_pkg::ST_COOL: begin
            s_next.ocPresent = 1'b0;
            if (msTick) begin
               s_next.coolMs = s_reg.coolMs - 17'h1;
            end
            if (s_reg.coolMs == 17'h0) begin
               s_next.coolMs = 17'h0;
               s_next.gatePullDown = 1'b0;
               if (!s_reg.ocFault) begin
                  s_next.state = overcurrent_retry_field_pkg::ST_RUN;
               end else if (retrySel == `RETRY_NONE) begin
                  s_next.state = overcurrent_retry_field_pkg::ST_HOLD;
               end else if (retryLimit == 3'h0) begin
                  s_next.state = overcurrent_retry_field_pkg::ST_RUN;
               end else if (s_reg.retriesUsed >= retryLimit) begin
                  s_next.state = overcurrent_retry_field_pkg::ST_HOLD;
               end else begin
                  // own counter, not shared with integrity fault
                  s_next.retriesUsed = s_reg.retriesUsed + 3'h1;
                  s_next.resetMs = `CNT_RESET_MS;
                  s_next.resetRun = 1'b1;
                  s_next.state = overcurrent_retry_field_pkg::ST_RUN;
               end
            end
         end
         default: begin
            s_next.ocPresent = 1'b0;
            if (!s_reg.ocFault) begin
               s_next.coolMs = coolLen;
               s_next.retriesUsed = 3'h0;
               s_next.resetRun = 1'b0;
               s_next.state = overcurrent_retry_field_pkg::ST_COOL;
            end
         end
      endcase

      s_next.gateEnable = (s_next.state == overcurrent_retry_field_pkg::ST_RUN) & s_reg.onSync[1] & ~s_next.gatePullDown;

      // Register writes; hardware set beats software clear
      if (regWrEn) begin
         if (regAddr == `OFF_FAULT) begin
            if (regWrData[`BIT_OVERCURRENT_FAULT_LATCH] && !faultEvent) begin
               s_next.ocFault = 1'b0;
            end
         end else if (regAddr == `OFF_RETRY) begin
            s_next.retryCtl = regWrData;
         end else if (regAddr == `OFF_LIMCFG) begin
            s_next.limCfg = regWrData;
         end else if (regAddr == `OFF_TIMING) begin
            s_next.timingCfg = regWrData;
         end else if (regAddr == `OFF_NVLIM) begin
            s_next.nvLim = regWrData;
         end else if (regAddr >= `OFF_SCRATCH_LO && regAddr <= `OFF_SCRATCH_HI) begin
            scratch_next[3'(regAddr - `OFF_SCRATCH_LO)] = regWrData;
         end
      end

      if (regRdEn) begin
         s_next.rdData = 8'h00;
         if (regAddr == `OFF_PRESENT) begin
            s_next.rdData[`BIT_OC_PRESENT] = s_reg.ocPresent;
         end else if (regAddr == `OFF_FAULT) begin
            s_next.rdData[`BIT_OVERCURRENT_FAULT_LATCH] = s_reg.ocFault;
         end else if (regAddr == `OFF_RETRY) begin
            s_next.rdData = s_reg.retryCtl;
         end else if (regAddr == `OFF_LIMCFG) begin
            s_next.rdData = s_reg.limCfg;
         end else if (regAddr == `OFF_TIMING) begin
            s_next.rdData = s_reg.timingCfg;
         end else if (regAddr == `OFF_RESTART) begin
            s_next.rdData[`BIT_DELAY_RUN] = (s_reg.state == overcurrent_retry_field_pkg::ST_COOL);
         end else if (regAddr == `OFF_NVLIM) begin
            s_next.rdData = s_reg.nvLim;
         end else if (regAddr >= `OFF_SCRATCH_LO && regAddr <= `OFF_SCRATCH_HI) begin
            s_next.rdData = scratch_reg[3'(regAddr - `OFF_SCRATCH_LO)];
         end
      end

      // Both factors widened first so the product is never cut at five or ten bits
      s_next.limitUv = 16'({11'h000, vilimMv} * {6'h00, ratio});
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= RESET_STATE;
         for (int i = 0; i < 7; i++) begin
            scratch_reg[i] <= 8'h00;
         end
      end else begin
         s_reg <= s_next;
         for (int i = 0; i < 7; i++) begin
            scratch_reg[i] <= scratch_next[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign regRdData = s_reg.rdData;
   assign gateEnable = s_reg.gateEnable;
   assign gatePullDown = s_reg.gatePullDown;
   assign delayRunning = (s_reg.state == overcurrent_retry_field_pkg::ST_COOL);
   assign limitSenseMv = vilimMv;
   assign fastPulldownMv = {vilimMv, 1'b0};
   assign effectiveLimitUv = s_reg.limitUv;

endmodule : overcurrent_retry_field_limit
`default_nettype wire

//--- tb/overcurrent_retry_field_limit_props.sv
// Concurrent checks on the overcurrent retry block ports
`timescale 1ns/1ps
`default_nettype none
module overcurrent_retry_field_limit_props #(
   parameter int unsigned MS_CYCLES = 125000
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic timerThresholdPin,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [7:0] regRdData,
   input wire logic gateEnable,
   input wire logic gatePullDown,
   input wire logic delayRunning,
   input wire logic [4:0] limitSenseMv,
   input wire logic [5:0] fastPulldownMv
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////
   a_fast_twice: assert property (fastPulldownMv == {limitSenseMv, 1'b0})
      else $error("fast threshold not twice the limit");
   a_limit_range: assert property (limitSenseMv >= 5'd15 && limitSenseMv <= 5'd30)
      else $error("limit out of range");
   a_limit_write: assert property (regWrEn && regAddr == 8'h0D |=> limitSenseMv == 5'd15 + $past(regWrData[3:0]))
      else $error("limit write not applied");
   // Sync plus detect plus output register
   a_trip_pulldown: assert property ($rose(timerThresholdPin) && gateEnable |-> ##[3:5] gatePullDown)
      else $error("no pull-down after threshold");
   a_gate_excl: assert property (!(gateEnable && gatePullDown))
      else $error("gate driven and pulled down");
   a_cool_start: assert property ($rose(gatePullDown) |-> !gateEnable && delayRunning)
      else $error("cooling not started at turn-off");
   a_delay_holds: assert property ($rose(delayRunning) |-> delayRunning [*8])
      else $error("delay flag too short");
   a_no_on_cool: assert property (delayRunning |-> !gateEnable)
      else $error("gate on during cooling");
   a_delay_read: assert property (regRdEn && regAddr == 8'hA2 |=> regRdData[0] == $past(delayRunning))
      else $error("delay flag readback wrong");
endmodule : overcurrent_retry_field_limit_props
bind overcurrent_retry_field_limit overcurrent_retry_field_limit_props #(.MS_CYCLES(MS_CYCLES)) u_props (.ref_clk(ref_clk), .rst_n(rst_n),
   .timerThresholdPin(timerThresholdPin), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
   .regRdEn(regRdEn), .regRdData(regRdData), .gateEnable(gateEnable), .gatePullDown(gatePullDown),
   .delayRunning(delayRunning), .limitSenseMv(limitSenseMv), .fastPulldownMv(fastPulldownMv));
`default_nettype wire

//--- tb/oc_load_model.sv
// Behavioural pass transistors, sense resistor, timer and load
`timescale 1ns/1ps
`default_nettype none
module oc_load_model #(
   parameter int TMR_CYC = 40
) (
   input wire logic ref_clk,
   input wire logic gateEnable,
   input wire logic overload,
   input wire logic pgAllow,
   input wire logic [11:0] senseSet,
   output logic limitEngagedPin,
   output logic timerThresholdPin,
   output logic powerGoodPin,
   output logic [11:0] outputSenseMv
);
   int tmr = 0;
   initial begin
      limitEngagedPin = 1'b0;
      timerThresholdPin = 1'b0;
      powerGoodPin = 1'b0;
      outputSenseMv = 12'h000;
   end
   always @(posedge ref_clk) begin
      // No current flows with the gates off
      limitEngagedPin <= gateEnable && overload;
      // Timer bleeds off at once; slow answer set by TMR_CYC
      tmr <= limitEngagedPin ? tmr + 1 : 0;
      timerThresholdPin <= limitEngagedPin && tmr >= TMR_CYC;
      powerGoodPin <= gateEnable && pgAllow;
      outputSenseMv <= gateEnable ? senseSet : 12'h000;
   end
endmodule : oc_load_model
`default_nettype wire

//--- tb/overcurrent_retry_field_limit_tb_top.sv
// Self-checking bench for the overcurrent retry block
`timescale 1ns/1ps
`default_nettype none
`include "overcurrent_retry_field_defs.svh"
module overcurrent_retry_field_limit_tb_top;
   localparam int COOL = 512;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic overload = 1'b0;
   logic pgAllow = 1'b1;
   logic onReq = 1'b1;
   logic [11:0] senseSet = 12'h000;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic regWrEn = 1'b0;
   logic regRdEn = 1'b0;
   logic rdPend = 1'b0;
   logic limitEngagedPin, timerThresholdPin, powerGoodPin, gateEnable, gatePullDown, delayRunning;
   logic [11:0] outputSenseMv;
   logic [7:0] regRdData;
   logic [4:0] limitSenseMv;
   logic [5:0] fastPulldownMv;
   logic [15:0] effectiveLimitUv;
   logic [7:0] expQ[$];
   integer seed = 32'h1CEF25A9;
   int nErrors = 0;
   int totalChecks = 0;
   // One-cycle millisecond keeps the long timers short
   overcurrent_retry_field_limit #(.MS_CYCLES(1)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .limitEngagedPin(limitEngagedPin),
      .timerThresholdPin(timerThresholdPin), .powerGoodPin(powerGoodPin), .turnOnRequestPin(onReq),
      .outputSenseMv(outputSenseMv), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regRdData(regRdData), .gateEnable(gateEnable), .gatePullDown(gatePullDown),
      .delayRunning(delayRunning), .limitSenseMv(limitSenseMv), .fastPulldownMv(fastPulldownMv),
      .effectiveLimitUv(effectiveLimitUv));
   oc_load_model u_load (.ref_clk(ref_clk), .gateEnable(gateEnable), .overload(overload), .pgAllow(pgAllow),
      .senseSet(senseSet), .limitEngagedPin(limitEngagedPin), .timerThresholdPin(timerThresholdPin),
      .powerGoodPin(powerGoodPin), .outputSenseMv(outputSenseMv));
   ////////////////////////////////////////
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      totalChecks++;
      if (s !== e) begin
         nErrors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic results();
      $display("checks=%0d errors=%0d", totalChecks, nErrors);
      if (nErrors == 0 && totalChecks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge ref_clk);
      regWrEn <= 1'b0;
      @(posedge ref_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      expQ.push_back(e);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge ref_clk);
      regRdEn <= 1'b0;
      @(posedge ref_clk);
   endtask : rd
   task automatic trip();
      int k;
      overload <= 1'b1;
      for (k = 0; k < 300 && gatePullDown !== 1'b1; k++) begin
         @(posedge ref_clk);
      end
      overload <= 1'b0;
   endtask : trip
   task automatic waitOn(input int lim, output int n);
      n = 0;
      while (gateEnable !== 1'b1 && n < lim) begin
         @(posedge ref_clk);
         n++;
      end
   endtask : waitOn
   task automatic setFb(input logic [7:0] c, input logic [11:0] s);
      wr(`OFF_LIMCFG, c);
      senseSet <= s;
      repeat (8) @(posedge ref_clk);
   endtask : setFb
   ////////////////////////////////////////
   always @(posedge ref_clk) begin
      rdPend <= regRdEn;
      if (rdPend) begin
         chk(regRdData, expQ.pop_front());
      end
   end
   initial begin
      repeat (70000) @(posedge ref_clk);
      nErrors++;
      results();
   end
   initial begin
      int i;
      int n;
      logic [7:0] v;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk(fastPulldownMv, 6'd40);
      rd(`OFF_NVLIM, `NVLIM_RESET);
      rd(`OFF_LIMCFG, `NVLIM_RESET);
      rd(`OFF_RETRY, 8'h00);
      rd(8'h50, 8'h00);
      for (i = 8'hE9; i <= 8'hEF; i++) begin
         v = $random(seed);
         wr(8'(i), v);
         rd(8'(i), v);
      end
      for (i = 0; i < 16; i++) begin
         v = $random(seed);
         v[3:0] = 4'(i);
         wr(`OFF_LIMCFG, v);
         chk(limitSenseMv, 15 + i);
         chk(fastPulldownMv, 30 + 2 * i);
      end
      for (i = 0; i < 4; i++) begin
         setFb(8'h05 | 8'(i << 4), 12'd0);
         chk(effectiveLimitUv, i == 3 ? 20000 : (i == 2 ? 10000 : 2000 << i));
      end
      setFb(8'h05, 12'd450);
      chk(effectiveLimitUv, 16'd11000);
      setFb(8'h05, 12'd900);
      chk(effectiveLimitUv, 16'd20000);
      setFb(8'h45, 12'd1350);
      chk(effectiveLimitUv, 16'd15000);
      setFb(8'h45, 12'd2500);
      chk(effectiveLimitUv, 16'd10000);
      setFb(8'hC5, 12'd1800);
      chk(effectiveLimitUv, 16'd10000);
      setFb(8'h85, 12'd0);
      chk(effectiveLimitUv, 16'd20000);
      pgAllow <= 1'b0;
      setFb(8'h05, 12'd900);
      chk(effectiveLimitUv, 16'd2000);
      pgAllow <= 1'b1;
      // Turn-on request gates the drive
      onReq <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk(gateEnable, 1'b0);
      onReq <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk(gateEnable, 1'b1);
      overload <= 1'b1;
      repeat (10) @(posedge ref_clk);
      rd(`OFF_PRESENT, 8'h01);
      trip();
      rd(`OFF_PRESENT, 8'h00);
      rd(`OFF_FAULT, 8'h01);
      rd(`OFF_RESTART, 8'h01);
      waitOn(COOL + 40, n);
      chk(gateEnable, 1'b0);
      chk(delayRunning, 1'b0);
      wr(`OFF_FAULT, 8'h01);
      waitOn(COOL + 40, n);
      chk(n > COOL - 20 && n < COOL + 20, 1'b1);
      wr(`OFF_RETRY, 8'h03);
      for (i = 0; i < 3; i++) begin
         wr(`OFF_TIMING, 8'(i));
         trip();
         waitOn((COOL << i) + 40, n);
         chk(n > (COOL << i) - 10 && n < (COOL << i) + 20, 1'b1);
      end
      wr(`OFF_TIMING, 8'h00);
      wr(`OFF_RETRY, 8'h02);
      for (i = 0; i < 8; i++) begin
         trip();
         waitOn(COOL + 40, n);
         chk(gateEnable, i < 7);
      end
      wr(`OFF_FAULT, 8'h01);
      waitOn(COOL + 40, n);
      wr(`OFF_RETRY, 8'h01);
      trip();
      waitOn(COOL + 40, n);
      repeat (16500) @(posedge ref_clk);
      trip();
      waitOn(COOL + 40, n);
      chk(gateEnable, 1'b1);
      // Without power good the counter must not be returned
      pgAllow <= 1'b0;
      repeat (16500) @(posedge ref_clk);
      trip();
      waitOn(COOL + 40, n);
      chk(gateEnable, 1'b0);
      results();
   end
endmodule : overcurrent_retry_field_limit_tb_top
`default_nettype wire
